// ---- pswc_regs.svh ----
// register map, field positions, codes and timing figures
// for the power state and wake controller; included by pswc_top.sv
//
// Summary of operation
// - one normal state D0 and two sleep states D1, D2 via state select
// - in D1/D2 only the control register reads; ready flag held clear
// - after reset or return from sleep, writes ignored until one read
// - any write to byte-test in D1/D2 returns to D0, select back to D0
// - select 01 enters D1; internal and PHY clocks run, host/MAC gated
// - D1 enables wake frame detection; receive wake block off in D2
// - frame in D1 sets wake source 10b; pin only with both enables
// - carrier already present on D2 entry wakes at once
// - carrier in D2 sets wake source 01b; pin only with both enables
// - wake event flag sets on any wake event with its matching enable, whatever pin enable
// - wake request and flag held until source or enable cleared; W1C
// - host interrupt from wake flag when enabled, independent of pin
// - pulse select 1 gives 50ms pin pulse, 0 gives level
// - pin drops when source, matching enable or pin enable cleared
// - configuration kept through D1 and D2
// - wake source field is readable
// - ready set again within 2ms of the wake write
`ifndef PSWC_REGS_SVH
`define PSWC_REGS_SVH

`define PSWC_ADDR_PMC        8'h00
`define PSWC_ADDR_BYTE_TEST  8'h04
`define PSWC_ADDR_INTERRUPT_STATUS    8'h08
`define PSWC_ADDR_INT_EN     8'h0C

`define PSWC_PMC_READY       0
`define PSWC_PMC_SEL_LO      1
`define PSWC_PMC_SEL_HI      2
`define PSWC_PMC_SRC_LO      3
`define PSWC_PMC_SRC_HI      4
`define PSWC_PMC_PIN_EN      5
`define PSWC_PMC_PULSE       6
`define PSWC_PMC_WFDE        7
`define PSWC_PMC_EDWE        8
`define PSWC_INT_WAKE        0

`define PSWC_SRC_NONE        2'h0
`define PSWC_SRC_ENERGY      2'h1
`define PSWC_SRC_FRAME       2'h2

// arbitrary test pattern
`define PSWC_BYTE_TEST_VAL   32'h5A0F_C3A5

`define PSWC_RESP_OKAY       2'h0
`define PSWC_RESP_SLVERR     2'h2

`define PSWC_CLK_MHZ         50
`define PSWC_READY_TIME_US   2000
`define PSWC_PULSE_TIME_US   50000

`endif

// ---- pswc_pkg.sv ----
// types shared by the power state and wake controller
// assumes an AXI4-Lite master with 8-bit addresses
package pswc_pkg;

   typedef enum logic [1:0] {
      PSWC_D0 = 2'h0,
      PSWC_D1 = 2'h1,
      PSWC_D2 = 2'h2
   } pswc_state_type;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pswc_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pswc_axi_rsp_type;

   typedef struct packed {
      logic host_if;
      logic mac;
      logic rx_pm;
      logic internal;
   } pswc_clk_en_type;

endpackage

// ---- pswc_top.sv ----
// power state and wake controller: D0/D1/D2, ready flag, wake pin,
// wake event flag and host interrupt, registers over AXI4-Lite
// assumes wake_frame is a one-cycle pulse on aclk; energy is async
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pswc_regs.svh"

module pswc_top #(
   parameter int READY_CYCLES = `PSWC_READY_TIME_US * `PSWC_CLK_MHZ,
   parameter int PULSE_CYCLES = `PSWC_PULSE_TIME_US * `PSWC_CLK_MHZ
) (
   // clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // register bus
   input  wire pswc_pkg::pswc_axi_req_type axi_req,
   output var  pswc_pkg::pswc_axi_rsp_type axi_rsp,
   // wake sources
   input  wire logic                       wake_frame,
   input  wire logic                       energy,
   // wake pin, host interrupt, clock gating
   output var  logic                       wake_event,
   output var  logic                       host_irq,
   output var  pswc_pkg::pswc_clk_en_type  clk_en
);
   import pswc_pkg::*;

   pswc_state_type  state_q;
   logic            ready_q;
   logic            read_seen_q;
   logic [31:0]     rdy_cnt_q;
   logic            wfde_q;
   logic            edwe_q;
   logic            pin_en_q;
   logic            pulse_q;
   logic [1:0]      src_q;
   logic            flag_q;
   logic            irq_en_q;
   logic            req_q;
   logic            pin_q;
   logic [31:0]     pin_cnt_q;
   logic            irq_q;
   logic            ed_meta_q;
   logic            ed_sync_q;
   pswc_clk_en_type clk_en_q;
   logic            wr_acc_q;
   logic            bvalid_q;
   logic [1:0]      bresp_q;
   logic            arready_q;
   logic            rvalid_q;
   logic [31:0]     rdata_q;
   logic [1:0]      rresp_q;

   logic [31:0] bmask;
   logic [31:0] wset;
   logic        sleeping;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_ok;
   logic        wr_pmc;
   logic        wr_wake;
   logic        wr_sts;
   logic        wr_en;
   logic        wr_known;
   logic        wake_req;
   logic [31:0] pmc_view;
   logic [31:0] rd_d;
   logic [1:0]  rresp_d;
   logic [1:0]  sel_new;

   // energy detect arrives from the analog front end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ed_meta_q <= 1'b0;
         ed_sync_q <= 1'b0;
      end else begin
         ed_meta_q <= energy;
         ed_sync_q <= ed_meta_q;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bmask[8*i +: 8] = {8{axi_req.wstrb[i]}};
      end
   end

   assign wset     = axi_req.wdata & bmask;
   assign sleeping = (state_q != PSWC_D0);
   assign wr_fire  = wr_acc_q;
   assign rd_fire  = arready_q & axi_req.arvalid;
   // a write counts only after one read and, while not ready, only the
   // wake write to byte-test gets through
   assign wr_ok    = read_seen_q &
                     (ready_q | (axi_req.awaddr == `PSWC_ADDR_BYTE_TEST));
   assign wr_pmc   = wr_fire & wr_ok & ready_q &
                     (axi_req.awaddr == `PSWC_ADDR_PMC);
   assign wr_wake  = wr_fire & wr_ok & sleeping &
                     (axi_req.awaddr == `PSWC_ADDR_BYTE_TEST);
   assign wr_sts   = wr_fire & wr_ok & ready_q &
                     (axi_req.awaddr == `PSWC_ADDR_INTERRUPT_STATUS);
   assign wr_en    = wr_fire & wr_ok & ready_q &
                     (axi_req.awaddr == `PSWC_ADDR_INT_EN);
   assign sel_new  = (axi_req.wdata[`PSWC_PMC_SEL_HI:`PSWC_PMC_SEL_LO] &
                      bmask[`PSWC_PMC_SEL_HI:`PSWC_PMC_SEL_LO]) |
                     (state_q & ~bmask[`PSWC_PMC_SEL_HI:`PSWC_PMC_SEL_LO]);

   // internal wake request follows source and matching enable
   assign wake_req = ((src_q == `PSWC_SRC_FRAME) & wfde_q) |
                     ((src_q == `PSWC_SRC_ENERGY) & edwe_q);

   // power state; writes of 11 are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= PSWC_D0;
      end else if (wr_wake) begin
         state_q <= PSWC_D0;
      end else if (wr_pmc && !sleeping) begin
         if (sel_new == PSWC_D1) begin
            state_q <= PSWC_D1;
         end else if (sel_new == PSWC_D2) begin
            state_q <= PSWC_D2;
         end
      end
   end

   // ready: cleared in sleep, set a fixed time after reset or wake write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_q   <= 1'b0;
         rdy_cnt_q <= 32'(READY_CYCLES);
      end else if (wr_pmc && !sleeping &&
                   (sel_new == PSWC_D1 || sel_new == PSWC_D2)) begin
         ready_q   <= 1'b0;
         rdy_cnt_q <= 32'h0000_0000;
      end else if (wr_wake) begin
         rdy_cnt_q <= 32'(READY_CYCLES);
      end else if (!sleeping && !ready_q) begin
         if (rdy_cnt_q <= 32'h0000_0001) begin
            ready_q <= 1'b1;
         end
         rdy_cnt_q <= rdy_cnt_q - 32'h0000_0001;
      end
   end

   // writes stay dead until the host has read once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_seen_q <= 1'b0;
      end else if (rd_fire) begin
         read_seen_q <= 1'b1;
      end else if (wr_wake) begin
         read_seen_q <= 1'b0;
      end
   end

   // configuration is untouched by state changes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wfde_q   <= 1'b0;
         edwe_q   <= 1'b0;
         pin_en_q <= 1'b0;
         pulse_q  <= 1'b0;
         irq_en_q <= 1'b0;
      end else begin
         if (wr_pmc && axi_req.wstrb[0]) begin
            wfde_q   <= axi_req.wdata[`PSWC_PMC_WFDE];
            pin_en_q <= axi_req.wdata[`PSWC_PMC_PIN_EN];
            pulse_q  <= axi_req.wdata[`PSWC_PMC_PULSE];
         end
         if (wr_pmc && axi_req.wstrb[1]) begin
            edwe_q <= axi_req.wdata[`PSWC_PMC_EDWE];
         end
         if (wr_en) begin
            irq_en_q <= wset[`PSWC_INT_WAKE];
         end
      end
   end

   // wake source: detection wins over a clearing write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_q <= `PSWC_SRC_NONE;
      end else if (state_q == PSWC_D1 && wake_frame) begin
         src_q <= `PSWC_SRC_FRAME;
      end else if (state_q == PSWC_D2 && ed_sync_q) begin
         // level test, so carrier present at entry wakes at once
         src_q <= `PSWC_SRC_ENERGY;
      end else if (wr_pmc) begin
         src_q <= src_q & ~wset[`PSWC_PMC_SRC_HI:`PSWC_PMC_SRC_LO];
      end
   end

   // wake event flag, cleared by writing 1 only once the request is gone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (wake_req) begin
         flag_q <= 1'b1;
      end else if (wr_sts && wset[`PSWC_INT_WAKE]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q & irq_en_q;
      end
   end

   // wake pin: new events only on a rising request edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q     <= 1'b0;
         pin_q     <= 1'b0;
         pin_cnt_q <= 32'h0000_0000;
      end else begin
         req_q <= wake_req;
         if (!wake_req || !pin_en_q) begin
            pin_q     <= 1'b0;
            pin_cnt_q <= 32'h0000_0000;
         end else if (!req_q) begin
            pin_q     <= 1'b1;
            pin_cnt_q <= pulse_q ? 32'(PULSE_CYCLES) : 32'h0000_0000;
         end else if (pulse_q && pin_q) begin
            if (pin_cnt_q <= 32'h0000_0001) begin
               pin_q <= 1'b0;
            end
            pin_cnt_q <= pin_cnt_q - 32'h0000_0001;
         end
      end
   end

   // clock enables per state; internal clock off only in D2
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_en_q <= '{host_if: 1'b1, mac: 1'b1, rx_pm: 1'b1,
                       internal: 1'b1};
      end else begin
         clk_en_q.host_if  <= (state_q == PSWC_D0);
         clk_en_q.mac      <= (state_q == PSWC_D0);
         clk_en_q.rx_pm    <= (state_q != PSWC_D2);
         clk_en_q.internal <= (state_q != PSWC_D2);
      end
   end

   // write channel: address and data taken together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_acc_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= `PSWC_RESP_OKAY;
      end else begin
         wr_acc_q <= !wr_acc_q && !bvalid_q &&
                     axi_req.awvalid && axi_req.wvalid;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? `PSWC_RESP_OKAY : `PSWC_RESP_SLVERR;
         end else if (axi_req.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign wr_known = (axi_req.awaddr == `PSWC_ADDR_PMC) ||
                     (axi_req.awaddr == `PSWC_ADDR_BYTE_TEST) ||
                     (axi_req.awaddr == `PSWC_ADDR_INTERRUPT_STATUS) ||
                     (axi_req.awaddr == `PSWC_ADDR_INT_EN);

   always_comb begin
      pmc_view = 32'h0000_0000;
      pmc_view[`PSWC_PMC_READY] = ready_q;
      pmc_view[`PSWC_PMC_SEL_HI:`PSWC_PMC_SEL_LO] = state_q;
      pmc_view[`PSWC_PMC_SRC_HI:`PSWC_PMC_SRC_LO] = src_q;
      pmc_view[`PSWC_PMC_PIN_EN] = pin_en_q;
      pmc_view[`PSWC_PMC_PULSE]  = pulse_q;
      pmc_view[`PSWC_PMC_WFDE]   = wfde_q;
      pmc_view[`PSWC_PMC_EDWE]   = edwe_q;
   end

   // read decode; only the control register answers while not ready
   always_comb begin
      rd_d    = 32'h0000_0000;
      rresp_d = `PSWC_RESP_OKAY;
      if (axi_req.araddr == `PSWC_ADDR_PMC) begin
         rd_d = pmc_view;
      end else if (!ready_q) begin
         rd_d = 32'h0000_0000;
      end else if (axi_req.araddr == `PSWC_ADDR_BYTE_TEST) begin
         rd_d = `PSWC_BYTE_TEST_VAL;
      end else if (axi_req.araddr == `PSWC_ADDR_INTERRUPT_STATUS) begin
         rd_d[`PSWC_INT_WAKE] = flag_q;
      end else if (axi_req.araddr == `PSWC_ADDR_INT_EN) begin
         rd_d[`PSWC_INT_WAKE] = irq_en_q;
      end else begin
         rresp_d = `PSWC_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `PSWC_RESP_OKAY;
      end else begin
         arready_q <= !arready_q && !rvalid_q && axi_req.arvalid;
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_d;
            rresp_q  <= rresp_d;
         end else if (axi_req.rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign axi_rsp.awready = wr_acc_q;
   assign axi_rsp.wready  = wr_acc_q;
   assign axi_rsp.bvalid  = bvalid_q;
   assign axi_rsp.bresp   = bresp_q;
   assign axi_rsp.arready = arready_q;
   assign axi_rsp.rvalid  = rvalid_q;
   assign axi_rsp.rdata   = rdata_q;
   assign axi_rsp.rresp   = rresp_q;
   assign wake_event      = pin_q;
   assign host_irq        = irq_q;
   assign clk_en          = clk_en_q;

endmodule
`default_nettype wire

// ---- pswc_top_props.sv ----
// port-level assertions for the power state and wake controller
// assumes binding onto pswc_top, single aclk domain, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "pswc_regs.svh"
module pswc_props #(
   parameter int READY_CYCLES = `PSWC_READY_TIME_US * `PSWC_CLK_MHZ,
   parameter int PULSE_CYCLES = `PSWC_PULSE_TIME_US * `PSWC_CLK_MHZ
) (
   // clock and reset
   input wire logic                       aclk,
   input wire logic                       aresetn,
   // register bus
   input wire pswc_pkg::pswc_axi_req_type axi_req,
   input wire pswc_pkg::pswc_axi_rsp_type axi_rsp,
   // wake side
   input wire logic                       wake_frame,
   input wire logic                       energy,
   input wire logic                       wake_event,
   input wire logic                       host_irq,
   input wire pswc_pkg::pswc_clk_en_type  clk_en
);
   import pswc_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_pin_sleep;
      $rose(wake_event) |-> !clk_en.host_if;
   endproperty
   a_pin_sleep: assert property (p_pin_sleep)
      else $error("wake pin rose outside sleep");
   // energy path adds two sync flops, so its cause lies further back
   property p_pin_cause;
      $rose(wake_event) |-> $past(wake_frame, 2) || $past(energy, 4);
   endproperty
   a_pin_cause: assert property (p_pin_cause)
      else $error("wake pin rose without a wake source");
   property p_gate_mac;
      !clk_en.host_if |-> !clk_en.mac;
   endproperty
   a_gate_mac: assert property (p_gate_mac)
      else $error("mac clock on while host side gated");
   property p_gate_d2;
      !clk_en.internal |-> !clk_en.rx_pm && !clk_en.host_if;
   endproperty
   a_gate_d2: assert property (p_gate_d2)
      else $error("clock left on with internal clock off");
   property p_gate_rx;
      !clk_en.rx_pm |-> !clk_en.internal;
   endproperty
   a_gate_rx: assert property (p_gate_rx)
      else $error("receive wake block off outside deep sleep");
   property p_sleep_rd;
      axi_rsp.arready && axi_req.araddr != `PSWC_ADDR_PMC
         && !clk_en.host_if |=> axi_rsp.rvalid && axi_rsp.rdata == 32'h0;
   endproperty
   a_sleep_rd: assert property (p_sleep_rd)
      else $error("sleep read returned data");
   property p_unmapped;
      axi_rsp.arready && axi_req.araddr > 8'h0C
         |=> axi_rsp.rresp == `PSWC_RESP_SLVERR;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   property p_wr_ans;
      axi_rsp.awready && axi_req.awaddr <= 8'h0C
         |=> axi_rsp.bvalid && axi_rsp.bresp == `PSWC_RESP_OKAY;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write not answered okay next cycle");
   // answer one cycle after arready, then still valid one cycle later unless rready was seen
   property p_rd_ans;
      axi_rsp.arready |=> axi_rsp.rvalid
         ##1 (axi_rsp.rvalid || $past(axi_req.rready));
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read answer late or dropped");
   property p_rd_hold;
      axi_rsp.rvalid && !axi_req.rready
         |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed before taken");
   c_pin: cover property ($rose(wake_event));
   c_irq: cover property ($rose(host_irq));
   c_d2: cover property ($fell(clk_en.internal));
endmodule
bind pswc_top pswc_props #(
   .READY_CYCLES(READY_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES)
) i_pswc_props (
   .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .wake_frame(wake_frame), .energy(energy),
   .wake_event(wake_event), .host_irq(host_irq), .clk_en(clk_en)
);
`default_nettype wire

// ---- pswc_wake_src.sv ----
// wake source model: frame detector pulse and line carrier level
// assumes commands from the bench on aclk
`timescale 1ns/1ps
`default_nettype none
module pswc_wake_src (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // commands from the bench
   input  wire logic frame_cmd,
   input  wire logic energy_cmd,
   // to the controller
   output var  logic wake_frame,
   output var  logic energy
);
   logic frame_q;
   // a held command still yields a single-cycle frame pulse
   always_ff @(posedge aclk) begin
      frame_q    <= frame_cmd & aresetn;
      wake_frame <= frame_cmd & ~frame_q & aresetn;
   end
   always_ff @(posedge aclk) begin
      energy <= energy_cmd;
   end
endmodule
`default_nettype wire

// ---- tb_power_state_wake_control.sv ----
// bench for pswc_top: host accesses over AXI4-Lite, wake source model
// assumes short ready and pulse counts set below
`timescale 1ns/1ps
`default_nettype none
module tb_power_state_wake_control;
   import pswc_pkg::*;
   localparam int RDY = 20;
   localparam int PUL = 30;
   logic             aclk, aresetn, frame_cmd, energy_cmd;
   logic             wake_frame, energy, wake_event, host_irq;
   pswc_axi_req_type req;
   pswc_axi_rsp_type rsp;
   pswc_clk_en_type  clk_en;
   logic [31:0]      rd;
   logic [1:0]       rr;
   int               errors, cmp_count, n, k;
   pswc_top #(.READY_CYCLES(RDY), .PULSE_CYCLES(PUL)) i_pswc_top (
      .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .wake_frame(wake_frame), .energy(energy),
      .wake_event(wake_event), .host_irq(host_irq), .clk_en(clk_en));
   pswc_wake_src i_pswc_wake_src (
      .aclk(aclk), .aresetn(aresetn), .frame_cmd(frame_cmd),
      .energy_cmd(energy_cmd), .wake_frame(wake_frame), .energy(energy));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask
   task end_of_test;
      if (errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // waits are open ended; only the watchdog ends a hung access
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.awaddr  <= a;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do begin @(posedge aclk); end while (rsp.awready !== 1'b1);
      req.awvalid <= 1'b0;
      req.wvalid  <= 1'b0;
      do begin @(posedge aclk); end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      do begin @(posedge aclk); end while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      // late rready makes the slave hold its answer for a cycle
      @(posedge aclk);
      req.rready <= 1'b1;
      do begin @(posedge aclk); end while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   initial begin
      repeat (3000) @(posedge aclk);
      errors++;
      end_of_test;
   end
   initial begin
      req = '0;
      frame_cmd = 1'b0;
      energy_cmd = 1'b0;
      aresetn = 1'b0;
      errors = 0;
      cmp_count = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      wr(8'h0C, 32'h1);
      rdr(8'h00); chk(rd[0], 32'h0);
      repeat (RDY + 5) @(posedge aclk);
      rdr(8'h00); chk(rd, 32'h1);
      rdr(8'h0C); chk(rd, 32'h0);
      wr(8'h0C, 32'h1);
      rdr(8'h10); chk(rr, 32'h2);
      // light sleep, static pin, frame wake
      wr(8'h00, 32'hA2);
      rdr(8'h00); chk(rd, 32'hA2);
      chk(clk_en, 32'h3);
      rdr(8'h0C); chk(rd, 32'h0);
      wr(8'h0C, 32'h0);
      @(posedge aclk) frame_cmd <= 1'b1;
      @(posedge aclk) frame_cmd <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(wake_event, 32'h1);
      chk(host_irq, 32'h1);
      rdr(8'h00); chk(rd, 32'hB2);
      wr(8'h04, 32'h0);
      repeat (RDY + 5) @(posedge aclk);
      wr(8'h0C, 32'h0);
      rdr(8'h00); chk(rd, 32'hB1);
      rdr(8'h0C); chk(rd, 32'h1);
      wr(8'h08, 32'h1);
      rdr(8'h08); chk(rd, 32'h1);
      wr(8'h00, 32'hB0);
      rdr(8'h08); chk(wake_event, 32'h0);
      wr(8'h08, 32'h1);
      rdr(8'h08); chk(rd, 32'h0);
      chk(host_irq, 32'h0);
      // deep sleep with carrier already present, pulsed pin
      @(posedge aclk) energy_cmd <= 1'b1;
      repeat (6) @(posedge aclk);
      wr(8'h00, 32'h164);
      k = 0;
      while (wake_event !== 1'b1 && k < 20) begin @(posedge aclk); k++; end
      n = 0;
      while (wake_event === 1'b1 && n < 99) begin n++; @(posedge aclk); end
      chk(n, PUL);
      chk(clk_en, 32'h0);
      rdr(8'h00); chk(rd, 32'h16C);
      wr(8'h04, 32'h0);
      repeat (RDY + 5) @(posedge aclk);
      rdr(8'h00); chk(rd[0], 32'h1);
      @(posedge aclk) energy_cmd <= 1'b0;
      wr(8'h00, 32'h168);
      rdr(8'h00); chk(rd, 32'h161);
      end_of_test;
   end
endmodule
`default_nettype wire
